// [src/psl_pkg.sv]
// Package of constants and carrier types for the pixel serializer link control block.
package psl_pkg;

	// ----------------------------------------------------------------
	// Register map (Avalon-MM byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [3:0] REG_CTRL_ADDR   = 4'h0;
	localparam logic [3:0] REG_CONFIG_ADDR = 4'h4;
	localparam logic [3:0] REG_STATUS_ADDR = 4'h8;

	localparam logic       REG_CTRL_RESET   = 1'h0;
	localparam logic [7:0] REG_CONFIG_RESET = 8'h00;

	// Config register fields.
	localparam int CFG_MODE_LSB  = 0;
	localparam int CFG_MAP_BIT   = 2;
	localparam int CFG_SWING_BIT = 3;
	localparam int CFG_DEEMP_LSB = 4;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_MHZ      = 50;
	localparam int CTRL_WINDOW_PCLK = 130;
	localparam int CTRL_MIN_PULSE   = 3;
	localparam int STOP_FREQ_MHZ    = 3;
	// Longest link clock period tolerated, in system cycles (rounded down).
	localparam int STOP_CYCLES      = SYS_CLK_MHZ / STOP_FREQ_MHZ;
	localparam int LOCK_EDGES       = 4;
	localparam int WORD_BITS        = 28;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0]
	{
		MODE_NORMAL_NOFILT = 2'b00,
		MODE_NORMAL_FILT   = 2'b01,
		MODE_GEN2          = 2'b10,
		MODE_GEN1          = 2'b11
	} psl_mode_t;

	typedef enum logic [2:0]
	{
		DEEMP_OFF   = 3'b000,
		DEEMP_3DB   = 3'b001,
		DEEMP_6DB   = 3'b010,
		DEEMP_9DB   = 3'b011,
		DEEMP_12DB  = 3'b100
	} psl_deemp_t;

	typedef enum logic [1:0]
	{
		LNK_SLEEP = 2'b00,
		LNK_LOCK  = 2'b01,
		LNK_RUN   = 2'b10
	} psl_link_t;

	typedef struct packed
	{
		logic vertical_sync;
		logic horizontal_sync;
		logic display_enable;
	} psl_ctrl_t;

	typedef struct packed
	{
		psl_deemp_t deemphasis_level;
		logic       swing_select;
		logic       color_map_select;
		psl_mode_t  mode;
	} psl_cfg_t;

endpackage

// [src/psl_top.sv]
// Pixel serializer link control: word framing, control filter, configuration and sleep.
//
// Implementation choices: the address map and the Avalon-MM interface to the registers.
`timescale 1ns/100ps

module psl_top
	import psl_pkg::*;
(
	input  wire logic        SYS_CLK,              // System clock, 50 MHz.
	input  wire logic        RESETN,               // Asynchronous reset, active low.
	input  wire logic [3:0]  AVS_ADDRESS,          // Register byte address.
	input  wire logic        AVS_READ,             // Read request.
	input  wire logic        AVS_WRITE,            // Write request.
	input  wire logic [31:0] AVS_WRITEDATA,        // Write data.
	input  wire logic [3:0]  AVS_BYTEENABLE,       // Byte enables.
	output logic      [31:0] AVS_READDATA,         // Read data.
	output logic             AVS_WAITREQUEST,      // Stall while high.
	input  wire logic        LVDS_CLOCK_INPUT,     // Pixel clock from the source link.
	input  wire logic [23:0] PIXEL_RGB,            // Pixel data, sampled on clock rise.
	input  wire logic        DISPLAY_ENABLE,       // Display enable input.
	input  wire logic        HORIZONTAL_SYNC,      // Horizontal sync input.
	input  wire logic        VERTICAL_SYNC,        // Vertical sync input.
	input  wire logic [1:0]  MODE_SELECT_PIN,      // Compatibility mode strap.
	input  wire logic        COLOR_MAP_SELECT_PIN, // Lane 3 mapping strap.
	input  wire logic        COLOR_18BIT_PIN,      // High selects 18-bit colour.
	input  wire logic        SWING_SELECT_PIN,     // Output swing strap.
	input  wire logic [2:0]  DEEMPHASIS_PIN,       // De-emphasis strap code.
	input  wire logic        POWER_DOWN_N,         // Low powers the device down.
	output logic      [27:0] SERIAL_WORD,          // Word for the serializer.
	output logic             WORD_VALID,           // One-cycle pulse per word.
	output logic             LINK_ENABLE,          // Serial driver enabled.
	output logic             SWING_HIGH,           // Increased output swing.
	output logic [2:0]       DEEMPHASIS_LEVEL,     // Active de-emphasis code.
	output logic             DEEMPHASIS_ACTIVE,    // De-emphasis phase of current bit.
	output logic             COLOR_MAP_SELECT,     // Active lane 3 mapping.
	output logic             SLEEP                 // Stop-clock sleep state.
);

	// ----------------------------------------------------------------
	// Input synchronisers
	// ----------------------------------------------------------------
	localparam int NSYNC = 11;
	logic [NSYNC-1:0] sync1_q;
	logic [NSYNC-1:0] sync2_q;
	logic [NSYNC-1:0] async_in;
	logic [23:0]      rgb1_q;
	logic [23:0]      rgb2_q;

	assign async_in = {LVDS_CLOCK_INPUT, DISPLAY_ENABLE, HORIZONTAL_SYNC, VERTICAL_SYNC,
		POWER_DOWN_N, MODE_SELECT_PIN, COLOR_MAP_SELECT_PIN, COLOR_18BIT_PIN,
		SWING_SELECT_PIN, DEEMPHASIS_PIN[0]};

	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
			rgb1_q  <= '0;
			rgb2_q  <= '0;
		end
		else
		begin
			sync1_q <= async_in;
			sync2_q <= sync1_q;
			rgb1_q  <= PIXEL_RGB;
			rgb2_q  <= rgb1_q;
		end

	logic [1:0] demp_hi1_q;
	logic [1:0] demp_hi2_q;
	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
		begin
			demp_hi1_q <= '0;
			demp_hi2_q <= '0;
		end
		else
		begin
			demp_hi1_q <= DEEMPHASIS_PIN[2:1];
			demp_hi2_q <= demp_hi1_q;
		end

	logic       lclk_s;
	logic       pd_n_s;
	logic [2:0] ctrl_s;
	psl_cfg_t   pin_cfg;
	logic       c18_s;
	assign lclk_s = sync2_q[10];
	assign ctrl_s = sync2_q[9:7];
	assign pd_n_s = sync2_q[6];
	assign c18_s  = sync2_q[2];
	assign pin_cfg = '{mode: psl_mode_t'(sync2_q[5:4]), color_map_select: sync2_q[3],
		swing_select: sync2_q[1], deemphasis_level: psl_deemp_t'({demp_hi2_q, sync2_q[0]})};

	// ----------------------------------------------------------------
	// Register slave
	// ----------------------------------------------------------------
	logic     reg_en_q;
	psl_cfg_t reg_cfg_q;
	logic     rd_done_q;
	logic     pd_active;
	psl_cfg_t cfg;
	psl_link_t lnk_q;

	assign pd_active = !pd_n_s;
	assign cfg = reg_en_q ? reg_cfg_q : pin_cfg;

	// Writes complete at once; reads take one wait cycle so data comes from a flop.
	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
			rd_done_q <= 1'b0;
		else
			rd_done_q <= AVS_READ && !rd_done_q;

	always_comb
		AVS_WAITREQUEST = AVS_READ && !rd_done_q;

	// Sleep does not touch these flops; only reset and power-down clear them.
	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
		begin
			reg_en_q  <= REG_CTRL_RESET;
			reg_cfg_q <= psl_cfg_t'(REG_CONFIG_RESET[6:0]);
		end
		else if (pd_active)
		begin
			reg_en_q  <= REG_CTRL_RESET;
			reg_cfg_q <= psl_cfg_t'(REG_CONFIG_RESET[6:0]);
		end
		else if (AVS_WRITE && AVS_BYTEENABLE[0])
		begin
			if (AVS_ADDRESS == REG_CTRL_ADDR)
				reg_en_q <= AVS_WRITEDATA[0];
			else if (AVS_ADDRESS == REG_CONFIG_ADDR)
				reg_cfg_q <= psl_cfg_t'(AVS_WRITEDATA[6:0]);
		end

	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
			AVS_READDATA <= '0;
		else if (AVS_READ && !rd_done_q)
			unique case (AVS_ADDRESS)
				REG_CTRL_ADDR:   AVS_READDATA <= {31'h0, reg_en_q};
				REG_CONFIG_ADDR: AVS_READDATA <= {25'h0, reg_cfg_q};
				REG_STATUS_ADDR: AVS_READDATA <= {24'h0, cfg[4:0], lnk_q, !pd_active};
				default:         AVS_READDATA <= '0;
			endcase

	// ----------------------------------------------------------------
	// Link clock edge detect, stop detect and lock
	// ----------------------------------------------------------------
	logic       lclk_d1_q;
	logic       rise;
	logic [4:0] idle_cnt_q;
	logic [2:0] lock_cnt_q;
	assign rise = lclk_s && !lclk_d1_q;

	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
			lclk_d1_q <= 1'b0;
		else
			lclk_d1_q <= lclk_s;

	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
			idle_cnt_q <= '0;
		else if (rise)
			idle_cnt_q <= '0;
		else if (idle_cnt_q != 5'(STOP_CYCLES))
			idle_cnt_q <= idle_cnt_q + 5'h1;

	// A clock held static at either level looks the same: no rise for too long.
	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
		begin
			lnk_q      <= LNK_SLEEP;
			lock_cnt_q <= '0;
		end
		else if (pd_active || idle_cnt_q == 5'(STOP_CYCLES))
		begin
			lnk_q      <= LNK_SLEEP;
			lock_cnt_q <= '0;
		end
		else
			unique case (lnk_q)
				LNK_SLEEP: if (rise) lnk_q <= LNK_LOCK;
				LNK_LOCK:
					if (rise)
					begin
						lock_cnt_q <= lock_cnt_q + 3'h1;
						if (lock_cnt_q == 3'(LOCK_EDGES - 1))
							lnk_q <= LNK_RUN;
					end
				LNK_RUN: ;
				default: lnk_q <= LNK_SLEEP;
			endcase

	// ----------------------------------------------------------------
	// Video control signal filter
	// ----------------------------------------------------------------
	psl_ctrl_t in_ctrl;
	psl_ctrl_t tx_ctrl_q;
	assign in_ctrl = ctrl_s;
	logic      filt_on;
	logic      normal;
	assign normal  = !cfg.mode[1];
	assign filt_on = cfg.mode == MODE_NORMAL_FILT;

	logic [7:0] win_q [3];
	logic [1:0] trn_q [3];
	logic [1:0] stab_q [3];
	logic [2:0] in_vec;
	logic [2:0] tx_vec;
	assign in_vec = in_ctrl;
	assign tx_vec = tx_ctrl_q;

	// Index 0 enable, 1 hsync, 2 vsync; each channel has its own 130-clock window.
	for (genvar i = 0; i < 3; i++)
	begin : g_ctrl
		logic lim;
		logic pulse_ok;
		assign lim = (i == 2) ? (trn_q[i] == 2'h0) : (trn_q[i] != 2'h2);
		assign pulse_ok = (i == 2) || !filt_on || stab_q[i] == 2'(CTRL_MIN_PULSE - 1);
		always_ff @(posedge SYS_CLK or negedge RESETN)
			if (!RESETN)
			begin
				win_q[i]  <= '0;
				trn_q[i]  <= '0;
				stab_q[i] <= '0;
				tx_ctrl_q[2-i] <= 1'b0;
			end
			else if (rise)
			begin
				stab_q[i] <= (in_vec[2-i] != tx_vec[2-i] && stab_q[i] != 2'h2) ?
					stab_q[i] + 2'h1 : (in_vec[2-i] == tx_vec[2-i] ? 2'h0 : stab_q[i]);
				if (win_q[i] != 8'h0)
					win_q[i] <= win_q[i] - 8'h1;
				else
					trn_q[i] <= '0;
				if (!normal)
					tx_ctrl_q[2-i] <= in_vec[2-i];
				else if (in_vec[2-i] != tx_vec[2-i] && lim && pulse_ok
					&& (i != 2 || win_q[i] == 8'h0))
				begin
					tx_ctrl_q[2-i] <= in_vec[2-i];
					trn_q[i] <= (win_q[i] == 8'h0) ? 2'h1 : trn_q[i] + 2'h1;
					if (win_q[i] == 8'h0)
						win_q[i] <= 8'(CTRL_WINDOW_PCLK - 1);
				end
			end
	end

	// ----------------------------------------------------------------
	// Word builder: scrambler, balance and integrity
	// ----------------------------------------------------------------
	logic [15:0] lfsr_q;
	logic signed [7:0] disp_q;
	logic [23:0] mapped;
	logic [23:0] scr;
	logic [4:0]  ones;
	logic signed [7:0] wdisp;
	logic        inv;
	logic        integ;
	logic [1:0]  seq_q;

	// Lane 3 swap: the two MSBs of each colour move to the bottom when color_map_select is low.
	assign mapped = cfg.color_map_select ? rgb2_q :
		{rgb2_q[21:16], rgb2_q[23:22], rgb2_q[13:8], rgb2_q[15:14],
		rgb2_q[5:0], rgb2_q[7:6]};
	assign scr = (c18_s ? {mapped[23:18], 2'h0, mapped[15:10], 2'h0, mapped[7:2], 2'h0}
		: mapped) ^ {lfsr_q, lfsr_q[7:0]};

	always_comb
	begin
		ones = '0;
		for (int k = 0; k < 24; k++)
			ones = ones + 5'(scr[k]);
		wdisp = 8'(signed'({3'h0, ones})) * 8'sh2 - 8'sd24;
		inv = (disp_q > 0) == (wdisp > 0) && wdisp != 0;
		integ = ^{scr, seq_q[0]} ^ ^tx_ctrl_q;
	end

	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
		begin
			lfsr_q <= 16'hace1;
			disp_q <= '0;
			seq_q  <= '0;
			SERIAL_WORD <= '0;
			WORD_VALID  <= 1'b0;
		end
		else if (rise && lnk_q == LNK_RUN)
		begin
			lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
			disp_q <= inv ? disp_q - wdisp : disp_q + wdisp;
			seq_q  <= seq_q + 2'h1;
			// Integrity bit alternates data check and control code every two words.
			SERIAL_WORD <= {1'b1, 1'b0, inv, seq_q[1] ? ^tx_ctrl_q : integ,
				inv ? ~scr : scr};
			WORD_VALID  <= 1'b1;
		end
		else
			WORD_VALID <= 1'b0;

	// ----------------------------------------------------------------
	// Driver control and de-emphasis timing
	// ----------------------------------------------------------------
	logic [4:0] bit_q;
	logic       run;
	assign run = lnk_q == LNK_RUN && !pd_active;

	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
		begin
			LINK_ENABLE       <= 1'b0;
			SWING_HIGH        <= 1'b0;
			DEEMPHASIS_LEVEL  <= '0;
			DEEMPHASIS_ACTIVE <= 1'b0;
			COLOR_MAP_SELECT  <= 1'b0;
			SLEEP             <= 1'b0;
			bit_q             <= '0;
		end
		else
		begin
			LINK_ENABLE      <= run;
			SWING_HIGH       <= cfg.swing_select;
			DEEMPHASIS_LEVEL <= cfg.deemphasis_level;
			COLOR_MAP_SELECT <= cfg.color_map_select;
			SLEEP            <= !pd_active && lnk_q == LNK_SLEEP;
			bit_q            <= rise ? 5'h0 : bit_q + 5'h1;
			// Bits after the first unit interval following each link clock rise are de-emphasised.
			DEEMPHASIS_ACTIVE <= run && cfg.deemphasis_level != DEEMP_OFF
				&& bit_q != 5'h0;
		end

endmodule

// [verification/psl_deser_model.sv]
// Far-side model: a deserializer that counts words and checks their framing.
`timescale 1ns/100ps

module psl_deser_model
	import psl_pkg::*;
(
	input  wire logic        clk,      // System clock.
	input  wire logic        rst_n,    // Reset, active low.
	input  wire logic [27:0] word,     // Serial word.
	input  wire logic        valid,    // Word strobe.
	output logic      [15:0] n_words,  // Words received.
	output logic             frame_ok  // Every word framed.
);
	always_ff @(posedge clk or negedge rst_n)
		if (!rst_n)
		begin
			n_words  <= 16'h0000;
			frame_ok <= 1'b1;
		end
		else if (valid)
		begin
			n_words <= n_words + 16'h0001;
			if (word[27:26] !== 2'b10)
				frame_ok <= 1'b0;
		end
endmodule

// [verification/psl_props.sv]
// Port checker of the pixel serializer link control block.
`timescale 1ns/100ps

module psl_props
	import psl_pkg::*;
(
	input wire logic        SYS_CLK,              // Clock.
	input wire logic        RESETN,               // Reset.
	input wire logic [3:0]  AVS_ADDRESS,          // Address.
	input wire logic        AVS_READ,             // Read.
	input wire logic        AVS_WRITE,            // Write.
	input wire logic [31:0] AVS_WRITEDATA,        // Write data.
	input wire logic [3:0]  AVS_BYTEENABLE,       // Byte enables.
	input wire logic        AVS_WAITREQUEST,      // Stall.
	input wire logic        LVDS_CLOCK_INPUT,     // Link clock.
	input wire logic        COLOR_MAP_SELECT_PIN, // Map strap.
	input wire logic        SWING_SELECT_PIN,     // Swing strap.
	input wire logic [2:0]  DEEMPHASIS_PIN,       // De-emphasis strap.
	input wire logic        POWER_DOWN_N,         // Power-down.
	input wire logic [27:0] SERIAL_WORD,          // Word.
	input wire logic        WORD_VALID,           // Word strobe.
	input wire logic        LINK_ENABLE,          // Driver enable.
	input wire logic        SWING_HIGH,           // Swing.
	input wire logic [2:0]  DEEMPHASIS_LEVEL,     // De-emphasis.
	input wire logic        DEEMPHASIS_ACTIVE,    // De-emphasis phase.
	input wire logic        COLOR_MAP_SELECT,     // Map.
	input wire logic        SLEEP                 // Sleep.
);
	// ----------------------------------------------------------------
	// Helper logic
	// ----------------------------------------------------------------
	// The gap bound leaves room for the two-flop sampler and the sleep flop.
	logic       lk_q;
	logic       en_q;
	logic [5:0] gap_q;

	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
			lk_q <= 1'b0;
		else
			lk_q <= LVDS_CLOCK_INPUT;

	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
			gap_q <= 6'h00;
		else if ((LVDS_CLOCK_INPUT && !lk_q) || !POWER_DOWN_N)
			gap_q <= 6'h00;
		else if (gap_q != 6'h3f)
			gap_q <= gap_q + 6'h01;

	always_ff @(posedge SYS_CLK or negedge RESETN)
		if (!RESETN)
			en_q <= 1'b0;
		else if (!POWER_DOWN_N)
			en_q <= 1'b0;
		else if (AVS_WRITE && !AVS_WAITREQUEST && AVS_ADDRESS == REG_CTRL_ADDR && AVS_BYTEENABLE[0])
			en_q <= AVS_WRITEDATA[0];

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge SYS_CLK); endclocking
	default disable iff (!RESETN);

	chk_clock_bits: assert property (WORD_VALID |-> SERIAL_WORD[27:26] == 2'b10)
		else $error("clock bits wrong");
	chk_pd_quiet: assert property ((!POWER_DOWN_N)[*5] |-> !LINK_ENABLE && !WORD_VALID)
		else $error("link active in power-down");
	chk_sleep_quiet: assert property (SLEEP |-> !WORD_VALID)
		else $error("word sent while asleep");
	chk_stop_sleep: assert property (gap_q >= 6'h1c |-> SLEEP)
		else $error("stopped clock not detected");
	chk_lock_first: assert property ($fell(SLEEP) |-> (!WORD_VALID)[*8])
		else $error("word sent before lock");
	chk_pin_drive: assert property ((!en_q && POWER_DOWN_N && $stable(SWING_SELECT_PIN) && $stable(DEEMPHASIS_PIN))[*3] |-> SWING_HIGH == SWING_SELECT_PIN && DEEMPHASIS_LEVEL == DEEMPHASIS_PIN)
		else $error("strap not followed");
	chk_pin_map: assert property ((!en_q && POWER_DOWN_N && $stable(COLOR_MAP_SELECT_PIN))[*3] |-> COLOR_MAP_SELECT == COLOR_MAP_SELECT_PIN)
		else $error("map strap not followed");
	chk_read_wait: assert property ($rose(AVS_READ) |-> AVS_WAITREQUEST ##1 !AVS_WAITREQUEST)
		else $error("read wait wrong");

	chk_deemp_off: assert property (DEEMPHASIS_LEVEL == 3'h0 |-> !DEEMPHASIS_ACTIVE)
		else $error("de-emphasis active while off");
	chk_deemp_idle: assert property (!LINK_ENABLE |-> !DEEMPHASIS_ACTIVE)
		else $error("de-emphasis active with link off");

	cov_word: cover property (WORD_VALID);
	cov_deemp: cover property (DEEMPHASIS_ACTIVE);
	cov_sleep: cover property ($rose(SLEEP));
	cov_pd: cover property ($fell(POWER_DOWN_N));
endmodule

bind psl_top psl_props i_psl_props (.*);

// [verification/test_pixel_serializer_link_control.sv]
// Testbench of the pixel serializer link control block.
`timescale 1ns/100ps

module test_pixel_serializer_link_control
	import psl_pkg::*;
();
	logic        SYS_CLK = 1'b0;
	logic        RESETN = 1'b0;
	logic [3:0]  AVS_ADDRESS = 4'h0;
	logic        AVS_READ = 1'b0;
	logic        AVS_WRITE = 1'b0;
	logic [31:0] AVS_WRITEDATA = 32'h0;
	logic [3:0]  AVS_BYTEENABLE = 4'hf;
	logic        LVDS_CLOCK_INPUT = 1'b0;
	logic [23:0] PIXEL_RGB = 24'h0;
	logic        DISPLAY_ENABLE = 1'b0;
	logic        HORIZONTAL_SYNC = 1'b0;
	logic        VERTICAL_SYNC = 1'b0;
	logic [1:0]  MODE_SELECT_PIN = 2'h0;
	logic        COLOR_MAP_SELECT_PIN = 1'b0;
	logic        COLOR_18BIT_PIN = 1'b0;
	logic        SWING_SELECT_PIN = 1'b0;
	logic [2:0]  DEEMPHASIS_PIN = 3'h0;
	logic        POWER_DOWN_N = 1'b1;
	logic [31:0] AVS_READDATA, rd;
	logic [27:0] SERIAL_WORD;
	logic [2:0]  DEEMPHASIS_LEVEL;
	logic        AVS_WAITREQUEST, WORD_VALID, LINK_ENABLE, SWING_HIGH;
	logic        DEEMPHASIS_ACTIVE, COLOR_MAP_SELECT, SLEEP, frame_ok;
	logic        lnk_run = 1'b1;
	logic [1:0]  div_q = 2'h0;
	logic [15:0] n_words;
	int          mismatches = 0;
	int          n_checks = 0;

	always #10 SYS_CLK = ~SYS_CLK;

	// The link clock toggles every fourth cycle and stands still when stopped.
	always @(posedge SYS_CLK)
	begin
		div_q <= div_q + 2'h1;
		if (lnk_run && div_q == 2'h3)
		begin
			LVDS_CLOCK_INPUT <= ~LVDS_CLOCK_INPUT;
			if (LVDS_CLOCK_INPUT)
			begin
				PIXEL_RGB       <= PIXEL_RGB + 24'h010101;
				DISPLAY_ENABLE  <= PIXEL_RGB[7];
				HORIZONTAL_SYNC <= PIXEL_RGB[8];
			end
		end
	end

	psl_top i_psl_top (.*);
	psl_deser_model i_psl_deser_model (.clk(SYS_CLK), .rst_n(RESETN), .word(SERIAL_WORD),
		.valid(WORD_VALID), .n_words(n_words), .frame_ok(frame_ok));

	task automatic summarize();
		if (mismatches == 0 && n_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic give_up();
		mismatches++;
		summarize();
	endtask

	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		logic w;
		w = 1'b1;
		@(posedge SYS_CLK);
		AVS_ADDRESS   <= a;
		AVS_WRITEDATA <= d;
		AVS_WRITE     <= wr;
		AVS_READ      <= !wr;
		for (int i = 0; i < 20 && w; i++)
		begin
			@(posedge SYS_CLK);
			w = AVS_WAITREQUEST;
			rd = AVS_READDATA;
		end
		if (w)
			give_up();
		AVS_WRITE <= 1'b0;
		AVS_READ  <= 1'b0;
	endtask

	task automatic wait_sleep(input logic lvl);
		for (int i = 0; i < 400 && SLEEP !== lvl; i++)
			@(negedge SYS_CLK);
		if (SLEEP !== lvl)
			give_up();
	endtask

	task automatic wait_words();
		logic [15:0] n0;
		n0 = n_words;
		for (int i = 0; i < 200 && n_words < n0 + 16'h4; i++)
			@(negedge SYS_CLK);
		if (n_words < n0 + 16'h4)
			give_up();
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_defaults();
		bus(1'b1, 4'hc, 32'hff);
		bus(1'b0, 4'hc, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, REG_CTRL_ADDR, 32'h0);
		check(rd, {31'h0, REG_CTRL_RESET});
		bus(1'b0, REG_CONFIG_ADDR, 32'h0);
		check(rd, {24'h0, REG_CONFIG_RESET});
	endtask

	task automatic t_run();
		wait_sleep(1'b0);
		wait_words();
		bus(1'b0, REG_STATUS_ADDR, 32'h0);
		check(rd[2:0], 3'b101);
		check(LINK_ENABLE, 1'b1);
	endtask

	task automatic t_pins();
		for (int m = 0; m < 4; m++)
		begin
			@(posedge SYS_CLK);
			MODE_SELECT_PIN <= m[1:0];
			repeat (4) @(posedge SYS_CLK);
			bus(1'b0, REG_STATUS_ADDR, 32'h0);
			check(rd[4:3], m[1:0]);
		end
		for (int d = 0; d < 5; d++)
		begin
			@(posedge SYS_CLK);
			DEEMPHASIS_PIN       <= d[2:0];
			SWING_SELECT_PIN     <= d[0];
			COLOR_MAP_SELECT_PIN <= d[1];
			repeat (4) @(posedge SYS_CLK);
			bus(1'b0, REG_STATUS_ADDR, 32'h0);
			check(rd[7:5], {d[0], d[0], d[1]});
			check({SWING_HIGH, COLOR_MAP_SELECT, DEEMPHASIS_LEVEL}, {d[0], d[1], d[2:0]});
		end
		@(posedge SYS_CLK);
		DEEMPHASIS_PIN       <= 3'h0;
		SWING_SELECT_PIN     <= 1'b0;
		COLOR_MAP_SELECT_PIN <= 1'b0;
		MODE_SELECT_PIN      <= 2'h0;
	endtask

	task automatic t_regs();
		bus(1'b1, REG_CONFIG_ADDR, 32'h4d);
		check(SWING_HIGH, 1'b0);
		bus(1'b1, REG_CTRL_ADDR, 32'h1);
		bus(1'b0, REG_CONFIG_ADDR, 32'h0);
		check(rd, 32'h4d);
		check({SWING_HIGH, COLOR_MAP_SELECT, DEEMPHASIS_LEVEL}, {2'b11, DEEMP_12DB});
	endtask

	task automatic t_sleep();
		@(posedge SYS_CLK);
		lnk_run <= 1'b0;
		wait_sleep(1'b1);
		bus(1'b0, REG_STATUS_ADDR, 32'h0);
		check(rd[2:1], LNK_SLEEP);
		bus(1'b0, REG_CONFIG_ADDR, 32'h0);
		check(rd, 32'h4d);
		bus(1'b0, REG_CTRL_ADDR, 32'h0);
		check(rd, 32'h1);
		lnk_run <= 1'b1;
		wait_sleep(1'b0);
		wait_words();
		check(DEEMPHASIS_LEVEL, DEEMP_12DB);
	endtask

	task automatic t_pd();
		@(posedge SYS_CLK);
		POWER_DOWN_N     <= 1'b0;
		SWING_SELECT_PIN <= 1'b1;
		repeat (4) @(posedge SYS_CLK);
		bus(1'b0, REG_STATUS_ADDR, 32'h0);
		check(rd[0], 1'b0);
		check(LINK_ENABLE, 1'b0);
		bus(1'b1, REG_CTRL_ADDR, 32'h1);
		POWER_DOWN_N <= 1'b1;
		bus(1'b0, REG_CTRL_ADDR, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, REG_CONFIG_ADDR, 32'h0);
		check(rd, 32'h0);
		check({SWING_HIGH, DEEMPHASIS_LEVEL}, {1'b1, DEEMP_OFF});
		wait_words();
	endtask

	initial
	begin
		repeat (3) @(posedge SYS_CLK);
		RESETN <= 1'b1;
		t_defaults();
		t_run();
		t_pins();
		t_regs();
		t_sleep();
		t_pd();
		check(frame_ok, 1'b1);
		summarize();
	end
endmodule
